// file: src/dfa_float_unit.sv
// Decimal floating add, subtract and multiply execution unit
//
// Decided for this implementation: the register addresses and strobed register access.
`default_nettype none
`include "dfa_defines.svh"
module dfa_float_unit (
  // Clock and reset
  input wire logic MCLK,
  input wire logic SYS_RST,
  // Register port
  input wire logic [4:0] ADDR,
  input wire logic [43:0] WR_DATA,
  input wire logic WR_STB,
  input wire logic RD_STB,
  output logic [43:0] RD_DATA,
  // Sequencer request
  input wire logic START,
  input wire logic [7:0] OPCODE,
  input wire logic [3:0] VARIATION,
  input wire logic [3:0] LIMITER,
  input wire logic [43:0] OPERAND,
  input wire logic ADDR_VALID,
  input wire logic PHASE_END,
  input wire logic RESUME,
  // Sequencer answer
  output logic BUSY,
  output logic DONE,
  output logic ALARM_STOP,
  output logic STOP_HOLD,
  output logic OVERFLOW_IND,
  output logic SINGLE_STEP_LATCH,
  output logic [3:0] IR_DIGIT1,
  output logic [43:0] ACCUMULATOR,
  output logic [43:0] EXTENSION_REGISTER,
  output logic IRQ
);
  import dfa_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  dfa_state_type state, next_state;
  logic [43:0] acc, next_acc, ext, next_ext, opnd, next_opnd;
  logic [39:0] ma, next_ma, mb, next_mb;
  logic signed [9:0] ea, next_ea, eb, next_eb, ex, next_ex;
  logic sub_op, next_sub_op, sgn, next_sgn;
  logic [3:0] lim, next_lim, mcnt, next_mcnt, dcnt, next_dcnt;
  logic [31:0] mpl, next_mpl, plo, next_plo;
  logic ovf, next_ovf, single_step_latch, next_sst, hold, next_hold;
  logic [3:0] irdig, next_irdig;
  logic done, next_done, alarm, next_alarm;
  logic [`DFA_EV_N-1:0] ev, next_ev;
  logic [39:0] add_a, add_b, add_sum;
  logic add_sub, add_cout;
  logic [9:0] diff;
  logic lim_on, op_neg, acc_neg, resume_evt;
  logic [31:0] mul_mant;
  logic [39:0] mul_r;
  logic signed [9:0] mul_e;
  logic rs1, rs2, rs3, rs_lvl, next_rs_lvl;
  logic [`DFA_EV_N-1:0] irq_st, next_irq_st, irq_en, next_irq_en;
  logic [43:0] rd, next_rd;
  logic wr_ctrl;

  dfa_bcd_addsub #(.DIGITS(10)) u_add (
    .a(add_a),
    .b(add_b),
    .sub(add_sub),
    .sum(add_sum),
    .cout(add_cout)
  );

  assign lim_on = lim != `DFA_LIM_OFF8 && lim != `DFA_LIM_OFF9
               && lim != `DFA_LIM_OFF0;
  assign op_neg = OPERAND[`DFA_NEG_BIT];
  assign acc_neg = acc[`DFA_NEG_BIT];
  assign diff = (ea >= eb) ? 10'(ea - eb) : 10'(eb - ea);
  assign wr_ctrl = WR_STB && ADDR == `DFA_A_CTRL;
  // Resume counts only once the second and third stages agree
  assign resume_evt = rs2 == rs3 && rs3 && !rs_lvl;

  // ----------------------------------------------------------------
  // Datapath and sequencing
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_acc = acc;
    next_ext = ext;
    next_opnd = opnd;
    next_ma = ma;
    next_mb = mb;
    next_ea = ea;
    next_eb = eb;
    next_ex = ex;
    next_sub_op = sub_op;
    next_sgn = sgn;
    next_lim = lim;
    next_mcnt = mcnt;
    next_dcnt = dcnt;
    next_mpl = mpl;
    next_plo = plo;
    next_irdig = irdig;
    next_done = 1'b0;
    next_alarm = 1'b0;
    next_ev = '0;
    add_a = ma;
    add_b = mb;
    add_sub = sub_op;
    // Top product digit zero means one more left step
    if (ma[`DFA_TOP_LSB +: `DFA_DIG] != 4'h0) begin
      mul_mant = ma[31:0];
      mul_r = {plo, 8'h00};
      mul_e = ex;
    end else begin
      mul_mant = {ma[27:0], plo[31:28]};
      mul_r = {plo[27:0], 12'h000};
      mul_e = ex - 10'sh001;
    end
    // Set beats clear for the indicators
    next_ovf = ovf;
    next_sst = single_step_latch;
    if (wr_ctrl && WR_DATA[`DFA_CT_CLR_OVF]) next_ovf = 1'b0;
    if (wr_ctrl && WR_DATA[`DFA_CT_CLR_SST]) next_sst = 1'b0;
    next_hold = hold;
    if (resume_evt) next_hold = 1'b0;
    if (single_step_latch && PHASE_END) next_hold = 1'b1;
    unique case (state)
      S_IDLE: begin
        if (START) begin
          next_done = 1'b1;
          if (!ADDR_VALID) begin
            next_alarm = 1'b1;
            next_ev[`DFA_EV_ALARM] = 1'b1;
          end else if (OPCODE == `DFA_OP_FADD ||
                       OPCODE == `DFA_OP_FSUB) begin
            next_done = 1'b0;
            next_opnd = OPERAND;
            // Magnitude form only for a variation of exactly one
            next_sub_op = acc_neg ^ (VARIATION == `DFA_V_ABS ? 1'b0
              : op_neg) ^ (OPCODE == `DFA_OP_FSUB);
            next_sgn = acc_neg;
            next_ea = dfa_bcd2bin(acc[`DFA_EXP_LSB +: 8]);
            next_eb = dfa_bcd2bin(OPERAND[`DFA_EXP_LSB +: 8]);
            next_ma = {8'h00, acc[31:0]};
            next_mb = {8'h00, OPERAND[31:0]};
            next_lim = LIMITER;
            next_mcnt = 4'h0;
            next_state = S_ALIGN;
          end else if (OPCODE == `DFA_OP_FMUL) begin
            next_opnd = OPERAND;
            next_sgn = acc_neg ^ op_neg;
            next_ex = dfa_bcd2bin(acc[`DFA_EXP_LSB +: 8])
                    + dfa_bcd2bin(OPERAND[`DFA_EXP_LSB +: 8])
                    - `DFA_EXP_BIAS;
            if (acc[`DFA_TOP_LSB +: `DFA_DIG] == 4'h0 ||
                OPERAND[`DFA_TOP_LSB +: `DFA_DIG] == 4'h0) begin
              // Unnormalized factor is taken as a zero product
              next_acc = '0;
              next_ext = '0;
            end else if (next_ex > `DFA_EXP_MAX) begin
              // Overflow is judged before the mantissas multiply
              next_ovf = 1'b1;
              next_acc = '0;
              next_ev[`DFA_EV_OVF] = 1'b1;
            end else begin
              next_done = 1'b0;
              next_ma = '0;
              next_mb = {8'h00, acc[31:0]};
              next_mpl = OPERAND[31:0];
              next_plo = '0;
              next_dcnt = 4'h0;
              next_state = S_MUL_ADD;
            end
          end
        end else if (WR_STB && ADDR == `DFA_A_ACC) begin
          next_acc = WR_DATA;
        end else if (WR_STB && ADDR == `DFA_A_EXT) begin
          next_ext = WR_DATA;
        end
      end
      S_ALIGN: begin
        // Digits shifted out are dropped; no rounding
        if (ea >= eb) begin
          next_mb = mb >> (diff * `DFA_DIG);
          next_ex = ea;
        end else begin
          next_ma = ma >> (diff * `DFA_DIG);
          next_ex = eb;
        end
        next_state = S_ADD;
      end
      S_ADD: begin
        next_ma = add_sum;
        next_state = (sub_op && !add_cout) ? S_FIX : S_NORM;
      end
      S_FIX: begin
        // Borrow: negate the wrapped difference and take the other sign
        add_a = '0;
        add_b = ma;
        add_sub = 1'b1;
        next_ma = add_sum;
        next_sgn = !sgn;
        next_state = S_NORM;
      end
      S_NORM: begin
        if (ma == '0) begin
          next_acc = '0;
          next_irdig = 4'h0;
          next_done = 1'b1;
          next_state = S_IDLE;
        end else if (ma[`DFA_CARRY_LSB +: `DFA_DIG] != 4'h0) begin
          next_ma = ma >> `DFA_DIG;
          next_ex = ex + 10'sh001;
          next_state = S_FINISH;
        end else if (ma[`DFA_TOP_LSB +: `DFA_DIG] == 4'h0) begin
          next_ma = ma << `DFA_DIG;
          next_ex = ex - 10'sh001;
          next_mcnt = mcnt + 4'h1;
        end else begin
          next_state = S_FINISH;
        end
      end
      S_FINISH: begin
        next_done = 1'b1;
        next_state = S_IDLE;
        if (ex > `DFA_EXP_MAX) begin
          next_ovf = 1'b1;
          next_acc = {3'h0, sgn, 8'h00, ma[31:0]};
          next_opnd = '0;
          next_ev[`DFA_EV_OVF] = 1'b1;
        end else if (ex < 10'sh000) begin
          next_acc = '0;
        end else begin
          next_acc = {3'h0, sgn, dfa_bin2bcd(ex[6:0]), ma[31:0]};
        end
        if (lim_on && mcnt > lim) begin
          next_irdig = 4'(`DFA_TEN - (mcnt - lim));
          next_sst = 1'b1;
          next_hold = 1'b1;
          next_ev[`DFA_EV_NORM] = 1'b1;
        end else begin
          next_irdig = 4'h0;
        end
      end
      S_MUL_ADD: begin
        // Repeated addition of the multiplicand per multiplier digit
        add_sub = 1'b0;
        if (mpl[3:0] != 4'h0) begin
          next_ma = add_sum;
          next_mpl = {mpl[31:4], mpl[3:0] - 4'h1};
        end else begin
          next_state = S_MUL_SHIFT;
        end
      end
      S_MUL_SHIFT: begin
        next_plo = {ma[3:0], plo[31:4]};
        next_ma = ma >> `DFA_DIG;
        next_mpl = mpl >> `DFA_DIG;
        next_dcnt = dcnt + 4'h1;
        next_state = (dcnt == 4'h7) ? S_MUL_DONE : S_MUL_ADD;
      end
      S_MUL_DONE: begin
        next_done = 1'b1;
        next_state = S_IDLE;
        if (mul_e < 10'sh000) begin
          next_acc = '0;
          next_ext = '0;
        end else begin
          next_acc = {3'h0, sgn, dfa_bin2bcd(mul_e[6:0]),
                      mul_mant};
          next_ext = {3'h0, sgn, mul_r};
        end
      end
    endcase
    if (next_done) next_ev[`DFA_EV_DONE] = 1'b1;
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      state <= S_IDLE;
      acc <= '0;
      ext <= '0;
      opnd <= '0;
      ma <= '0;
      mb <= '0;
      ea <= '0;
      eb <= '0;
      ex <= '0;
      sub_op <= 1'b0;
      sgn <= 1'b0;
      lim <= 4'h0;
      mcnt <= 4'h0;
      dcnt <= 4'h0;
      mpl <= '0;
      plo <= '0;
      ovf <= 1'b0;
      single_step_latch <= 1'b0;
      hold <= 1'b0;
      irdig <= 4'h0;
      done <= 1'b0;
      alarm <= 1'b0;
      ev <= '0;
    end else begin
      state <= next_state;
      acc <= next_acc;
      ext <= next_ext;
      opnd <= next_opnd;
      ma <= next_ma;
      mb <= next_mb;
      ea <= next_ea;
      eb <= next_eb;
      ex <= next_ex;
      sub_op <= next_sub_op;
      sgn <= next_sgn;
      lim <= next_lim;
      mcnt <= next_mcnt;
      dcnt <= next_dcnt;
      mpl <= next_mpl;
      plo <= next_plo;
      ovf <= next_ovf;
      single_step_latch <= next_sst;
      hold <= next_hold;
      irdig <= next_irdig;
      done <= next_done;
      alarm <= next_alarm;
      ev <= next_ev;
    end
  end

  // ----------------------------------------------------------------
  // Resume synchroniser, register port and interrupt
  // ----------------------------------------------------------------
  always_comb begin
    next_rs_lvl = (rs2 == rs3) ? rs3 : rs_lvl;
    next_irq_en = irq_en;
    if (WR_STB && ADDR == `DFA_A_IEN) next_irq_en = WR_DATA[3:0];
    next_irq_st = irq_st;
    if (WR_STB && ADDR == `DFA_A_ICLR)
      next_irq_st = irq_st & ~WR_DATA[3:0];
    next_irq_st = next_irq_st | ev;
    next_rd = '0;
    if (RD_STB) begin
      unique case (ADDR)
        `DFA_A_ACC: next_rd = acc;
        `DFA_A_EXT: next_rd = ext;
        `DFA_A_STAT: next_rd = {36'h0, irdig, 1'b0,
          state != S_IDLE, single_step_latch, ovf};
        `DFA_A_ISTAT: next_rd = {40'h0, irq_st};
        `DFA_A_IEN: next_rd = {40'h0, irq_en};
        default: next_rd = '0;
      endcase
    end
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      rs1 <= 1'b0;
      rs2 <= 1'b0;
      rs3 <= 1'b0;
      rs_lvl <= 1'b0;
      irq_st <= '0;
      irq_en <= '0;
      rd <= '0;
    end else begin
      rs1 <= RESUME;
      rs2 <= rs1;
      rs3 <= rs2;
      rs_lvl <= next_rs_lvl;
      irq_st <= next_irq_st;
      irq_en <= next_irq_en;
      rd <= next_rd;
    end
  end

  assign RD_DATA = rd;
  assign BUSY = state != S_IDLE;
  assign DONE = done;
  assign ALARM_STOP = alarm;
  assign STOP_HOLD = hold;
  assign OVERFLOW_IND = ovf;
  assign SINGLE_STEP_LATCH = single_step_latch;
  assign IR_DIGIT1 = irdig;
  assign ACCUMULATOR = acc;
  assign EXTENSION_REGISTER = ext;
  assign IRQ = |(irq_st & irq_en);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SYS_RST);

  property p_fadd_run;
    START && ADDR_VALID && state == S_IDLE && OPCODE == `DFA_OP_FADD
      |=> state == S_ALIGN ##[3:16] DONE;
  endproperty
  a_fadd_run: assert property (p_fadd_run)
    else $error("add did not run to completion");
  property p_fsub_abs;
    START && ADDR_VALID && state == S_IDLE && OPCODE == `DFA_OP_FSUB
      && VARIATION == `DFA_V_ABS
      |=> sub_op == !$past(acc[`DFA_NEG_BIT]);
  endproperty
  a_fsub_abs: assert property (p_fsub_abs)
    else $error("magnitude subtract took the operand sign");
  property p_signed_var;
    START && ADDR_VALID && state == S_IDLE && OPCODE == `DFA_OP_FADD
      && VARIATION != `DFA_V_ABS
      |=> sub_op == ($past(acc[`DFA_NEG_BIT]) ^ $past(op_neg));
  endproperty
  a_signed_var: assert property (p_signed_var)
    else $error("signed add variation not selected");
  property p_ovf;
    state == S_FINISH && ex > `DFA_EXP_MAX |=> OVERFLOW_IND && DONE
      && acc[`DFA_EXP_LSB +: 8] == 8'h00 && $stable(ext) && opnd == '0;
  endproperty
  a_ovf: assert property (p_ovf)
    else $error("overflow result wrong");
  property p_zero;
    state == S_NORM && ma == '0 |=> ACCUMULATOR == '0 && DONE;
  endproperty
  a_zero: assert property (p_zero)
    else $error("zero result not cleared");
  property p_limit;
    state == S_FINISH && lim_on && mcnt > lim
      |=> SINGLE_STEP_LATCH && STOP_HOLD && IR_DIGIT1 != 4'h0;
  endproperty
  a_limit: assert property (p_limit)
    else $error("limiter exceeded without halt");
  property p_digit_zero;
    state == S_FINISH && !(lim_on && mcnt > lim) |=> IR_DIGIT1 == 4'h0;
  endproperty
  a_digit_zero: assert property (p_digit_zero)
    else $error("holding digit not zero");
  property p_latch;
    $rose(IR_DIGIT1 != 4'h0) |-> SINGLE_STEP_LATCH;
  endproperty
  a_latch: assert property (p_latch)
    else $error("single step latch not set");
  property p_stop;
    SINGLE_STEP_LATCH && PHASE_END |=> STOP_HOLD;
  endproperty
  a_stop: assert property (p_stop)
    else $error("no stop at phase end");
  property p_alarm;
    START && state == S_IDLE && !ADDR_VALID |=> DONE && ALARM_STOP
      && $stable(ACCUMULATOR) && $stable(EXTENSION_REGISTER);
  endproperty
  a_alarm: assert property (p_alarm)
    else $error("address alarm changed registers");
  property p_mul;
    state == S_MUL_DONE && mul_e >= 10'sh000
      |=> ACCUMULATOR[43:40] == EXTENSION_REGISTER[43:40]
      && EXTENSION_REGISTER[7:0] == 8'h00;
  endproperty
  a_mul: assert property (p_mul)
    else $error("product placement wrong");
  c_add: cover property (state == S_FIX ##[1:12] DONE);
  c_mul: cover property (state == S_MUL_DONE ##1 DONE);
  c_norm: cover property (ev[`DFA_EV_NORM] ##[1:8] STOP_HOLD);
endmodule : dfa_float_unit
`default_nettype wire

// file: src/dfa_defines.svh
// Constants of the decimal floating execution unit
`ifndef DFA_DEFINES_SVH
`define DFA_DEFINES_SVH
// ----------------------------------------------------------------
// Word layout: sign digit, two exponent digits, eight mantissa digits
// ----------------------------------------------------------------
`define DFA_DIG 4
`define DFA_SIGN_LSB 40
`define DFA_EXP_LSB 32
`define DFA_TOP_LSB 28
`define DFA_CARRY_LSB 32
`define DFA_NEG_BIT 40
`define DFA_RADIX 10
`define DFA_EXP_MAX 10'sh063
`define DFA_EXP_BIAS 10'sh032
// ----------------------------------------------------------------
// Operation codes, variation and limiter codes
// ----------------------------------------------------------------
`define DFA_OP_FADD 8'h22
`define DFA_OP_FSUB 8'h23
`define DFA_OP_FMUL 8'h24
`define DFA_V_ABS 4'h1
`define DFA_LIM_OFF8 4'h8
`define DFA_LIM_OFF9 4'h9
`define DFA_LIM_OFF0 4'h0
`define DFA_TEN 4'hA
// ----------------------------------------------------------------
// Register port map and bits
// ----------------------------------------------------------------
`define DFA_A_ACC 5'h00
`define DFA_A_EXT 5'h04
`define DFA_A_STAT 5'h08
`define DFA_A_ISTAT 5'h0C
`define DFA_A_ICLR 5'h10
`define DFA_A_IEN 5'h14
`define DFA_A_CTRL 5'h18
`define DFA_ST_OVF 0
`define DFA_ST_SST 1
`define DFA_ST_BUSY 2
`define DFA_ST_DIG 4
`define DFA_CT_CLR_OVF 0
`define DFA_CT_CLR_SST 1
`define DFA_EV_DONE 0
`define DFA_EV_OVF 1
`define DFA_EV_NORM 2
`define DFA_EV_ALARM 3
`define DFA_EV_N 4
`endif

// file: src/dfa_pkg.sv
// Types and digit helpers of the decimal floating execution unit
`default_nettype none
`include "dfa_defines.svh"
package dfa_pkg;
  typedef enum logic [3:0] {
    S_IDLE, S_ALIGN, S_ADD, S_FIX, S_NORM, S_FINISH,
    S_MUL_ADD, S_MUL_SHIFT, S_MUL_DONE
  } dfa_state_type;

  function automatic logic signed [9:0] dfa_bcd2bin(input logic [7:0] d);
    dfa_bcd2bin = $signed({6'h00, d[7:4]}) * 10'sh00A
                + $signed({6'h00, d[3:0]});
  endfunction : dfa_bcd2bin

  function automatic logic [7:0] dfa_bin2bcd(input logic [6:0] v);
    logic [6:0] t;
    logic [6:0] o;
    t = v / 7'(`DFA_RADIX);
    o = v % 7'(`DFA_RADIX);
    dfa_bin2bcd = {t[3:0], o[3:0]};
  endfunction : dfa_bin2bcd
endpackage : dfa_pkg
`default_nettype wire

// file: src/dfa_bcd_addsub.sv
// Decimal digit-parallel adder and nines-complement subtractor
`default_nettype none
`include "dfa_defines.svh"
module dfa_bcd_addsub #(
  parameter int DIGITS = 10
) (
  // Operands; a - b when sub is high
  input wire logic [DIGITS*`DFA_DIG-1:0] a,
  input wire logic [DIGITS*`DFA_DIG-1:0] b,
  input wire logic sub,
  // Result; with sub, cout low means a borrow
  output logic [DIGITS*`DFA_DIG-1:0] sum,
  output logic cout
);
  logic [DIGITS:0] c;

  assign c[0] = sub;
  assign cout = c[DIGITS];

  for (genvar i = 0; i < DIGITS; i++) begin : g_dig
    logic [3:0] bd;
    logic [4:0] t;
    assign bd = sub ? 4'h9 - b[i*`DFA_DIG +: `DFA_DIG]
                    : b[i*`DFA_DIG +: `DFA_DIG];
    assign t = {1'b0, a[i*`DFA_DIG +: `DFA_DIG]} + {1'b0, bd}
             + {4'h0, c[i]};
    assign c[i+1] = t > 5'h09;
    assign sum[i*`DFA_DIG +: `DFA_DIG] =
      c[i+1] ? 4'(t - 5'h0A) : t[3:0];
  end
endmodule : dfa_bcd_addsub
`default_nettype wire

// file: verification/dfa_seq_model.sv
// Sequencer-side model: phase-end pulses and the resume handshake
`default_nettype none
module dfa_seq_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Stop handshake
  input wire logic stop_hold,
  output logic phase_end,
  output logic resume
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] cnt;
  // Resume comes late, like a slow operator, and drops once released
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt <= 5'h00;
      phase_end <= 1'b0;
      resume <= 1'b0;
    end else begin
      cnt <= cnt + 5'h01;
      phase_end <= (cnt == 5'h1F);
      if (!stop_hold) begin
        resume <= 1'b0;
      end else if (cnt == 5'h10) begin
        resume <= 1'b1;
      end
    end
  end
endmodule : dfa_seq_model
`default_nettype wire

// file: verification/dfa_float_unit_bench.sv
// Self-checking bench of the decimal floating execution unit
`default_nettype none
`include "dfa_defines.svh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin \
  miscompares++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module dfa_float_unit_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic MCLK = 1'b0, SYS_RST = 1'b1, WR_STB = 1'b0, RD_STB = 1'b0;
  logic START = 1'b0, ADDR_VALID = 1'b1;
  logic [4:0] ADDR = 5'h00;
  logic [7:0] OPCODE = 8'h00;
  logic [3:0] VARIATION = 4'h0, LIMITER = 4'h0, IR_DIGIT1;
  logic [43:0] WR_DATA = 44'h0, OPERAND = 44'h0, RD_DATA;
  logic [43:0] ACCUMULATOR, EXTENSION_REGISTER;
  logic PHASE_END, RESUME, BUSY, DONE, ALARM_STOP, STOP_HOLD;
  logic OVERFLOW_IND, SINGLE_STEP_LATCH, IRQ;
  int miscompares = 0, total_checks = 0;
  dfa_float_unit u_dut (.MCLK, .SYS_RST, .ADDR, .WR_DATA, .WR_STB, .RD_STB,
    .RD_DATA, .START, .OPCODE, .VARIATION, .LIMITER, .OPERAND, .ADDR_VALID,
    .PHASE_END, .RESUME, .BUSY, .DONE, .ALARM_STOP, .STOP_HOLD,
    .OVERFLOW_IND, .SINGLE_STEP_LATCH, .IR_DIGIT1, .ACCUMULATOR,
    .EXTENSION_REGISTER, .IRQ);
  dfa_seq_model u_seq (.clk(MCLK), .rst(SYS_RST), .stop_hold(STOP_HOLD),
    .phase_end(PHASE_END), .resume(RESUME));
  always #50 MCLK = ~MCLK;
  // ----------------------------------------------------------------
  // Reference arithmetic
  // ----------------------------------------------------------------
  function automatic longint b2i(input logic [43:0] w, input int n);
    longint r = 0;
    for (int i = n - 1; i >= 0; i--) r = r * 10 + w[i*4+:4];
    return r;
  endfunction : b2i
  function automatic logic [39:0] i2b(input longint v);
    logic [39:0] r;
    for (int i = 0; i < 10; i++) begin
      r[i*4+:4] = 4'(v % 10);
      v = v / 10;
    end
    return r;
  endfunction : i2b
  function automatic void ref_as(input logic [43:0] a, b, input logic sub,
      mag, output logic [43:0] r, output logic ov, output int m);
    longint ma, mb, s;
    int ea, eb, t;
    logic sa, sb;
    ma = b2i(a, 8);
    mb = b2i(b, 8);
    ea = int'(b2i(a >> 32, 2));
    eb = int'(b2i(b >> 32, 2));
    sa = a[40];
    sb = (b[40] & ~mag) ^ sub;
    r = 44'h0;
    ov = 1'b0;
    m = 0;
    if (ea < eb) begin
      {ea, eb} = {eb, ea};
      {ma, mb} = {mb, ma};
      {sa, sb} = {sb, sa};
    end
    // Digits shifted out are dropped, never rounded
    for (t = ea - eb; t > 0; t--) mb = mb / 10;
    s = (sa ? -ma : ma) + (sb ? -mb : mb);
    if (s == 0) return;
    if (s < 0) begin
      r[40] = 1'b1;
      s = -s;
    end
    if (s > 99999999) begin
      s = s / 10;
      ea++;
    end
    if (ea > 99) begin
      ov = 1'b1;
      r[39:0] = i2b(s);
      return;
    end
    while (s < 10000000) begin
      s = s * 10;
      ea--;
      m++;
    end
    if (ea < 0) r = 44'h0;
    else r[39:0] = i2b(longint'(ea) * 100000000 + s);
  endfunction : ref_as
  function automatic logic [87:0] ref_mul(input logic [43:0] a, b);
    longint p;
    int e;
    logic s;
    p = b2i(a, 8) * b2i(b, 8);
    e = int'(b2i(a >> 32, 2) + b2i(b >> 32, 2)) - 50;
    s = a[40] ^ b[40];
    if (p < 64'd1000000000000000) begin
      p = p * 10;
      e--;
    end
    return {3'h0, s, i2b(longint'(e) * 100000000 + p / 100000000),
      3'h0, s, i2b((p % 100000000) * 100)};
  endfunction : ref_mul
  function automatic logic [43:0] rw(input longint mt);
    return {3'h0, 1'($urandom), i2b(longint'(48 + $urandom % 8) * 100000000
      + mt)};
  endfunction : rw
  // ----------------------------------------------------------------
  // Bus and sequencer tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [4:0] a, input logic [43:0] d);
    @(posedge MCLK);
    ADDR <= a;
    WR_DATA <= d;
    WR_STB <= 1'b1;
    @(posedge MCLK);
    WR_STB <= 1'b0;
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [43:0] e);
    @(posedge MCLK);
    ADDR <= a;
    RD_STB <= 1'b1;
    @(posedge MCLK);
    RD_STB <= 1'b0;
    #1;
    `CHK(RD_DATA, e)
  endtask : rd
  task automatic op(input logic [7:0] c, input logic [3:0] v, l,
      input logic [43:0] a, b, input logic ok);
    logic [43:0] ea, ee;
    logic eo;
    int m, n;
    logic [3:0] ed;
    ee = 44'($urandom);
    wr(`DFA_A_CTRL, 44'h3);
    wr(`DFA_A_ACC, a);
    wr(`DFA_A_EXT, ee);
    n = 0;
    while (STOP_HOLD !== 1'b0 && n < 300) begin
      @(posedge MCLK);
      #1;
      n++;
    end
    `CHK(n < 300, 1'b1)
    ea = a;
    eo = 1'b0;
    m = 0;
    if (ok && c == `DFA_OP_FMUL) {ea, ee} = ref_mul(a, b);
    else if (ok) ref_as(a, b, c == `DFA_OP_FSUB, v == `DFA_V_ABS, ea, eo, m);
    ed = (l inside {4'h8, 4'h9, 4'h0} || m <= l) ? 4'h0 : 4'(10 - (m - l));
    @(posedge MCLK);
    START <= 1'b1;
    OPCODE <= c;
    VARIATION <= v;
    LIMITER <= l;
    OPERAND <= b;
    ADDR_VALID <= ok;
    @(posedge MCLK);
    START <= 1'b0;
    n = 0;
    // A one-cycle answer already stands just after the request edge
    #1;
    while (DONE !== 1'b1 && n < 200) begin
      @(posedge MCLK);
      #1;
      n++;
    end
    `CHK(n < 200, 1'b1)
    `CHK(BUSY, 1'b0)
    `CHK(ALARM_STOP, !ok)
    @(posedge MCLK);
    #1;
    `CHK(ACCUMULATOR, ea)
    `CHK(EXTENSION_REGISTER, ee)
    `CHK(OVERFLOW_IND, eo)
    if (ok && c != `DFA_OP_FMUL) begin
      `CHK(IR_DIGIT1, ed)
      `CHK(SINGLE_STEP_LATCH, ed != 4'h0)
      `CHK(STOP_HOLD, ed != 4'h0)
    end
  endtask : op
  task automatic summarize();
    $display("checks=%0d mismatches=%0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize
  initial begin
    #(30000 * 100);
    miscompares++;
    summarize();
  end
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    longint m1, m2;
    int n;
    void'($urandom(47));
    repeat (16) @(posedge MCLK);
    SYS_RST <= 1'b0;
    wr(`DFA_A_ACC, 44'h05112345678);
    rd(`DFA_A_ACC, 44'h05112345678);
    rd(5'h1C, 44'h0);
    op(`DFA_OP_FADD, 4'h0, 4'h0, 44'h05110000000, 44'h05110000000, 1);
    op(`DFA_OP_FADD, 4'h1, 4'h0, 44'h05212345678, 44'h15212345678, 1);
    op(`DFA_OP_FADD, 4'h5, 4'h0, 44'h05112345678, 44'h15112345678, 1);
    op(`DFA_OP_FADD, 4'h0, 4'h0, 44'h09990000000, 44'h09990000000, 1);
    op(`DFA_OP_FSUB, 4'h0, 4'h0, 44'h09990000000, 44'h19990000000, 1);
    op(`DFA_OP_FSUB, 4'h1, 4'h0, 44'h05210000000, 44'h15099999999, 1);
    op(`DFA_OP_FADD, 4'h0, 4'h0, 44'h05210000000, 44'h05099999999, 1);
    op(`DFA_OP_FSUB, 4'h0, 4'h6, 44'h05512345678, 44'h05512345600, 1);
    op(`DFA_OP_FSUB, 4'h2, 4'h8, 44'h05512345678, 44'h05512345600, 1);
    op(`DFA_OP_FADD, 4'h0, 4'h0, 44'h05112345678, 44'h05112345678, 0);
    op(`DFA_OP_FMUL, 4'h0, 4'h0, 44'h05120000000, 44'h15130000000, 1);
    op(`DFA_OP_FMUL, 4'h0, 4'h0, 44'h05099999999, 44'h05099999999, 1);
    op(`DFA_OP_FSUB, 4'h0, 4'h3, 44'h05512345678, 44'h05512345600, 1);
    n = 0;
    while (STOP_HOLD !== 1'b0 && n < 300) begin
      @(posedge MCLK);
      #1;
      n++;
    end
    `CHK(SINGLE_STEP_LATCH, 1'b1)
    while (PHASE_END !== 1'b1 && n < 400) begin
      @(posedge MCLK);
      #1;
      n++;
    end
    @(posedge MCLK);
    #1;
    `CHK(STOP_HOLD, 1'b1)
    rd(`DFA_A_STAT, 44'h72);
    wr(`DFA_A_IEN, 44'hF);
    rd(`DFA_A_ISTAT, 44'hF);
    `CHK(IRQ, 1'b1)
    wr(`DFA_A_ICLR, 44'hF);
    rd(`DFA_A_ISTAT, 44'h0);
    wr(`DFA_A_IEN, 44'h0);
    op(`DFA_OP_FADD, 4'h0, 4'h0, 44'h05110000000, 44'h05110000000, 1);
    `CHK(IRQ, 1'b0)
    wr(`DFA_A_IEN, 44'h1);
    #1;
    `CHK(IRQ, 1'b1)
    repeat (40) begin
      m1 = 10000000 + $urandom % 89999900;
      m2 = ($urandom % 3 == 0) ? m1 + $urandom % 100
        : 10000000 + $urandom % 89999900;
      op(($urandom % 4 == 0) ? `DFA_OP_FMUL : `DFA_OP_FADD + 8'($urandom % 2),
        4'($urandom % 10), 4'($urandom % 10), rw(m1), rw(m2),
        ($urandom % 8) != 0);
    end
    summarize();
  end
endmodule : dfa_float_unit_bench
`default_nettype wire
